// [hdl/logic_unit_map.vh]
// Encodings and field layout for the bitwise logic execution unit
`ifndef LOGIC_UNIT_MAP_VH
`define LOGIC_UNIT_MAP_VH
`define DATA_W 32
`define DATA_MSB 31
`define REG_IDX_W 4
`define OP_W 3
`define OP_AND 3'h0
`define OP_EXCLUSIVE_OR 3'h1
`define OP_INCLUSIVE_OR 3'h2
`define OP_BIT_CLEAR 3'h3
`define OP_OR_NOT 3'h4
`define COND_W 4
`define COND_EQ 4'h0
`define COND_NE 4'h1
`define COND_CS 4'h2
`define COND_CC 4'h3
`define COND_MI 4'h4
`define COND_PL 4'h5
`define COND_VS 4'h6
`define COND_VC 4'h7
`define COND_HI 4'h8
`define COND_LS 4'h9
`define COND_GE 4'ha
`define COND_LT 4'hb
`define COND_GT 4'hc
`define COND_LE 4'hd
`define COND_AL 4'he
`define FLAG_N 3
`define FLAG_Z 2
`define FLAG_C 1
`define FLAG_V 0
`define FLAGS_RESET 4'h0
`define ZERO_WORD 32'h00000000
`endif

// [hdl/cond_check.v]
// Condition code evaluator against the current flags
`timescale 1ns/10ps
`include "logic_unit_map.vh"
module cond_check (
   cond,
   flags,
   pass
);
   input wire [`COND_W-1:0] cond;
   input wire [3:0] flags;
   output reg pass;
   wire n = flags[`FLAG_N];
   wire z = flags[`FLAG_Z];
   wire c = flags[`FLAG_C];
   wire v = flags[`FLAG_V];
   always @* begin
      case (cond)
         `COND_EQ: pass = z;
         `COND_NE: pass = ~z;
         `COND_CS: pass = c;
         `COND_CC: pass = ~c;
         `COND_MI: pass = n;
         `COND_PL: pass = ~n;
         `COND_VS: pass = v;
         `COND_VC: pass = ~v;
         `COND_HI: pass = c & ~z;
         `COND_LS: pass = ~c | z;
         `COND_GE: pass = (n == v);
         `COND_LT: pass = (n != v);
         `COND_GT: pass = ~z & (n == v);
         `COND_LE: pass = z | (n != v);
         default: pass = 1'b1;
      endcase
   end
endmodule // cond_check

// [hdl/bitwise_logic_ops_unit.v]
// Single-cycle execute stage for the bitwise logical instructions
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`include "logic_unit_map.vh"
// Overview of operation
// - AND, exclusive OR or inclusive OR of first operand and second operand.
// - Bit clear: first operand AND complement of second operand.
// - Or not: first operand OR complement of second operand.
// - Result written to the register named by the destination field.
// - Flags change only when the flag-setting bit is given.
// - With flag setting, N takes result bit 31, Z marks an all-zero result.
// - With flag setting, C may take the shifter carry, else unchanged.
// - Overflow flag is never touched by these operations.
// - With a condition code, everything happens only if the flags pass.
module bitwise_logic_ops_unit (
   clk_sys,
   rst_n,
   issue_valid,
   op_sel,
   first_operand_reg,
   flexible_second_operand,
   shifter_carry_valid,
   shifter_carry,
   dest_reg_idx,
   set_flags,
   cond_code,
   rf_wr_en,
   rf_wr_idx,
   rf_wr_data,
   fwd_valid,
   fwd_idx,
   fwd_data,
   flags_out,
   cond_failed
);
   input wire clk_sys;
   input wire rst_n;
   input wire issue_valid;
   input wire [`OP_W-1:0] op_sel;
   input wire [`DATA_W-1:0] first_operand_reg;
   input wire [`DATA_W-1:0] flexible_second_operand;
   input wire shifter_carry_valid;
   input wire shifter_carry;
   input wire [`REG_IDX_W-1:0] dest_reg_idx;
   input wire set_flags;
   input wire [`COND_W-1:0] cond_code;
   output reg rf_wr_en;
   output reg [`REG_IDX_W-1:0] rf_wr_idx;
   output reg [`DATA_W-1:0] rf_wr_data;
   output wire fwd_valid;
   output wire [`REG_IDX_W-1:0] fwd_idx;
   output wire [`DATA_W-1:0] fwd_data;
   output wire [3:0] flags_out;
   output reg cond_failed;

   wire [`DATA_W-1:0] result_d;
   reg [3:0] flags_q;
   reg [3:0] flags_d;
   wire cond_pass;
   wire exec_go;
   wire flag_upd;
   wire n_next;
   wire z_next;
   wire c_next;
   genvar bit_i;

   // The condition is tested against flags left by the previous instruction
   cond_check u_cond (
      .cond(cond_code),
      .flags(flags_q),
      .pass(cond_pass)
   );

   assign exec_go = issue_valid & cond_pass;
   assign flag_upd = exec_go & set_flags;

   // Every bit is an identical slice, so the datapath is one generate loop
   generate
      for (bit_i = 0; bit_i < `DATA_W; bit_i = bit_i + 1) begin : g_bit
         wire a_bit;
         wire b_bit;
         wire and_bit;
         wire exclusive_or_bit;
         wire inclusive_or_bit;
         wire bit_clear_bit;
         wire or_not_bit;
         reg res_bit;
         assign a_bit = first_operand_reg[bit_i];
         assign b_bit = flexible_second_operand[bit_i];
         assign and_bit = a_bit & b_bit;
         assign exclusive_or_bit = a_bit ^ b_bit;
         assign inclusive_or_bit = a_bit | b_bit;
         assign bit_clear_bit = a_bit & ~b_bit;
         assign or_not_bit = a_bit | ~b_bit;
         always @* begin
            case (op_sel)
               `OP_AND: res_bit = and_bit;
               `OP_EXCLUSIVE_OR: res_bit = exclusive_or_bit;
               `OP_INCLUSIVE_OR: res_bit = inclusive_or_bit;
               `OP_BIT_CLEAR: res_bit = bit_clear_bit;
               `OP_OR_NOT: res_bit = or_not_bit;
               // Undefined codes give zero rather than a stale word
               default: res_bit = 1'b0;
            endcase
         end
         assign result_d[bit_i] = res_bit;
      end
   endgenerate

   assign n_next = result_d[`DATA_MSB];
   assign z_next = (result_d == `ZERO_WORD);
   // Without a shifter carry the old C is kept, so plain register operands leave it alone
   assign c_next = shifter_carry_valid ? shifter_carry : flags_q[`FLAG_C];

   always @* begin
      flags_d = flags_q;
      if (flag_upd) begin
         flags_d[`FLAG_N] = n_next;
         flags_d[`FLAG_Z] = z_next;
         flags_d[`FLAG_C] = c_next;
      end
      // V is deliberately carried over unchanged
      flags_d[`FLAG_V] = flags_q[`FLAG_V];
   end

   // Register index is trusted; stack pointer and program counter never arrive here
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         flags_q <= `FLAGS_RESET;
         rf_wr_en <= 1'b0;
         rf_wr_idx <= {`REG_IDX_W{1'b0}};
         rf_wr_data <= `ZERO_WORD;
         cond_failed <= 1'b0;
      end else begin
         flags_q <= flags_d;
         rf_wr_en <= exec_go;
         cond_failed <= issue_valid & ~cond_pass;
         if (exec_go) begin
            rf_wr_idx <= dest_reg_idx;
            rf_wr_data <= result_d;
         end
      end
   end

   // Forward path lets the very next instruction use the result without a stall
   assign fwd_valid = exec_go;
   assign fwd_idx = dest_reg_idx;
   assign fwd_data = result_d;
   assign flags_out = flags_q;
endmodule // bitwise_logic_ops_unit

// [dv/lu_partner_model.sv]
// Register file model fed by the unit's write port
`timescale 1ns/10ps
module reg_file_model (input wire clk_sys, rf_wr_en, input wire [3:0] rf_wr_idx, rd_sel,
   input wire [31:0] rf_wr_data, output wire [31:0] rd_val);
   logic [31:0] regs [16];
   always @(posedge clk_sys) begin
      if (rf_wr_en) regs[rf_wr_idx] <= rf_wr_data;
   end
   assign rd_val = regs[rd_sel];
endmodule // reg_file_model

// [dv/lu_monitor.sv]
// Port assertions for the bitwise logic unit
`timescale 1ns/10ps
module lu_monitor (input wire clk_sys, rst_n, issue_valid, set_flags, shifter_carry_valid, shifter_carry,
   rf_wr_en, fwd_valid, cond_failed, input wire [3:0] dest_reg_idx, fwd_idx, flags_out,
   input wire [31:0] rf_wr_data, fwd_data);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_wr_follows: assert property (fwd_valid |=> rf_wr_en && rf_wr_data == $past(fwd_data))
      else $error("no write");
   a_fwd_index: assert property (fwd_idx == dest_reg_idx) else $error("bad index");
   a_flags_hold: assert property (!(fwd_valid && set_flags) |=> $stable(flags_out))
      else $error("flags moved");
   a_nz_set: assert property (fwd_valid && set_flags |=> flags_out[3:2] == {$past(fwd_data[31]), $past(fwd_data) == 0})
      else $error("bad nz");
   a_c_take: assert property (fwd_valid && set_flags && shifter_carry_valid |=> flags_out[1] == $past(shifter_carry))
      else $error("bad carry");
   a_c_keep: assert property (fwd_valid && !shifter_carry_valid |=> $stable(flags_out[1]))
      else $error("carry moved");
   a_v_clear: assert property (!flags_out[0]) else $error("v moved");
   a_cond_skip: assert property (issue_valid && !fwd_valid |=> cond_failed && !rf_wr_en)
      else $error("ran on failed cond");
endmodule // lu_monitor
bind bitwise_logic_ops_unit lu_monitor lu_monitor_inst (.*);

// [dv/tb.sv]
// Self-checking bench for the bitwise logic unit
`timescale 1ns/10ps
module tb;
   logic clk_sys = 0, rst_n = 0, issue_valid = 0, set_flags = 0, shifter_carry_valid = 0, shifter_carry = 0;
   logic [2:0] op_sel = 0;
   logic [31:0] first_operand_reg = 32'hf0f000ff, flexible_second_operand = 0;
   logic [3:0] dest_reg_idx = 0, cond_code = 4'he, rd_sel = 0;
   wire rf_wr_en, fwd_valid, cond_failed;
   wire [3:0] rf_wr_idx, fwd_idx, flags_out;
   wire [31:0] rf_wr_data, fwd_data, rd_val;
   int n_mismatch = 0, check_count = 0;
   // Bit k is set when condition code k passes on flags N=1 Z=0 C=1 V=0
   logic [15:0] pass_map = 16'he996;
   logic [34:0] rows [5] = '{{3'h0, 32'hf0000000}, {3'h1, 32'h0ff0ffff}, {3'h2, 32'hfff0ffff},
      {3'h3, 32'h00f000ff}, {3'h4, 32'hf0ff00ff}};
   bitwise_logic_ops_unit bitwise_logic_ops_unit_inst (.*);
   reg_file_model reg_file_model_inst (.*);
   always #5 clk_sys = ~clk_sys;
   task cmp(input logic [31:0] g, e);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: %h vs %h", $time, g, e);
      end
   endtask
   // Destinations stay below 13 so the stack pointer and program counter are never named
   task run(input [2:0] o, input [31:0] y, input [3:0] d, c, input s, input [1:0] k);
      @(posedge clk_sys);
      op_sel <= o;
      flexible_second_operand <= y;
      dest_reg_idx <= d;
      cond_code <= c;
      set_flags <= s;
      {shifter_carry_valid, shifter_carry} <= k;
      issue_valid <= 1;
      @(posedge clk_sys);
      issue_valid <= 0;
      rd_sel <= d;
      #1 $display("test done");
   endtask
   task complete_run;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #3000;
      n_mismatch++;
      complete_run;
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1;
      foreach (rows[i]) begin
         run(rows[i][34:32], 32'hff00ff00, i[3:0], 4'he, 1, 0);
         cmp(rf_wr_data, rows[i][31:0]);
         cmp(fwd_data, rows[i][31:0]);
         cmp(rf_wr_en, 1);
         cmp(rf_wr_idx, i[3:0]);
         cmp(flags_out, {rows[i][31], 3'h0});
         @(posedge clk_sys);
         #1 cmp(rd_val, rows[i][31:0]);
      end
      run(3'h0, 0, 4'h1, 4'he, 1, 0);
      cmp(flags_out, 4'h4);
      run(3'h4, 0, 4'h2, 4'he, 0, 2'h3);
      cmp(flags_out, 4'h4);
      run(3'h1, 0, 4'h3, 4'h1, 1, 0);
      cmp(cond_failed, 1);
      cmp(rf_wr_en, 0);
      cmp(rf_wr_data, 32'hffffffff);
      run(3'h1, 0, 4'h4, 4'h0, 1, 2'h3);
      cmp(flags_out, 4'ha);
      for (int k = 0; k < 16; k++) begin
         run(3'h2, 0, 4'h6, k[3:0], 0, 0);
         cmp(cond_failed, !pass_map[k]);
         cmp(rf_wr_en, pass_map[k]);
      end
      cmp(flags_out, 4'ha);
      @(posedge clk_sys);
      rst_n <= 0;
      repeat (2) @(posedge clk_sys);
      #1 cmp(flags_out, 0);
      cmp(rf_wr_data, 0);
      cmp(rf_wr_en, 0);
      cmp(cond_failed, 0);
      cmp(rf_wr_idx, 0);
      @(posedge clk_sys);
      rst_n <= 1;
      run(3'h3, 32'h0000ffff, 4'h7, 4'hf, 1, 2'h3);
      cmp(rf_wr_data, 32'hf0f00000);
      cmp(flags_out, 4'ha);
      cmp(cond_failed, 0);
      @(posedge clk_sys);
      #1 cmp(rd_val, 32'hf0f00000);
      complete_run;
   end
endmodule // tb
